/* File: verilog/issr_top.sv */
// Overview of operation
// (R1) Status byte bit 3 is set while the error queue holds any entry.
// (R2) The service request mask has one enable bit per status byte bit.
// (R3) A set and enabled status byte bit drives the service request pin and indicator; bit 3 does so only once an entry arrives while it is enabled.
// (R4) An error queue request clears only by disabling, re-enabling or emptying.
// (R5) Status byte bit 5 summarizes enabled set bits of the event status register.
// (R6) Event bit 1 latches a bus control request, bit 6 a front panel key.
// (R7) A second event register with its own mask summarizes into status bit 2.
// (R8) Event bit 5 latches a syntax error; mask value 32 selects only it.
// (R9) Reading an event register clears its latched bits.
// (R10) Key codes are non-negative, knob counts negative with ccw offset by 32768.
// (R11) In remote mode a key is only reported and its normal function suppressed.
// (R12) Event registers are 8 bits, latch at onset, clear on read or clear status.
// (R13) The error queue keeps up to 20 entries until read out or preset.
// (R14) The service request falls as soon as no bit is both set and enabled.
//
// Added by the designer: the APB register port and the placing of the registers.
`include "issr_defs.svh"

module issr_top
#(
	parameter int ERRQ_DEPTH = `ISSR_ERRQ_DEPTH
)
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instrument events, pins from outside
	input wire logic err_push,
	input wire logic ctl_req,
	input wire logic syntax_err,
	input wire logic key_press,
	input wire logic [15:0] key_code,
	input wire logic [7:0] evb_set,
	input wire logic preset_cmd,
	// Service request and front panel
	output logic srq_n_o,
	output logic srq_n_oe,
	output logic svc_led,
	output logic key_local
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NS = 12;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_q, s2_q, s3_q, in_q;
	logic [15:0] kc1_q, kc2_q, kc3_q;

	assign raw = {evb_set, preset_cmd, key_press, syntax_err, ctl_req};

	// A change counts once the second and third stages agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			in_q <= '0;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < NS; i++)
				if (s2_q[i] == s3_q[i])
					in_q[i] <= s3_q[i];
		end
	end

	// Key code is steady long before the strobe is seen; no agreement check
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			kc1_q <= 16'h0000;
			kc2_q <= 16'h0000;
			kc3_q <= 16'h0000;
		end
		else
		begin
			kc1_q <= key_code;
			kc2_q <= kc1_q;
			kc3_q <= kc2_q;
		end
	end

	logic e_s1_q, e_s2_q, e_s3_q, e_q, e_prev_q, err_pulse;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			e_s1_q <= 1'b0;
			e_s2_q <= 1'b0;
			e_s3_q <= 1'b0;
			e_q <= 1'b0;
			e_prev_q <= 1'b0;
		end
		else
		begin
			e_s1_q <= err_push;
			e_s2_q <= e_s1_q;
			e_s3_q <= e_s2_q;
			if (e_s2_q == e_s3_q)
				e_q <= e_s3_q;
			e_prev_q <= e_q;
		end
	end
	assign err_pulse = e_q & ~e_prev_q;

	logic preset_s, key_s, prev_key_q, key_pulse;
	assign preset_s = in_q[3];
	assign key_s = in_q[2];
	assign key_pulse = key_s & ~prev_key_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_key_q <= 1'b0;
		else
			prev_key_q <= key_s;
	end

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic wr_en, rd_en, rd_setup, mapped;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	function automatic logic is_ofs(input logic [11:0] a,
		input logic [11:0] o);
		is_ofs = (a == o);
	endfunction

	assign mapped = is_ofs(paddr, `ISSR_OFS_STB) ||
		is_ofs(paddr, `ISSR_OFS_SRE) || is_ofs(paddr, `ISSR_OFS_ESR) ||
		is_ofs(paddr, `ISSR_OFS_ESE) || is_ofs(paddr, `ISSR_OFS_ESRB) ||
		is_ofs(paddr, `ISSR_OFS_ESEB) || is_ofs(paddr, `ISSR_OFS_ERRQ) ||
		is_ofs(paddr, `ISSR_OFS_KEY) || is_ofs(paddr, `ISSR_OFS_CTRL) ||
		is_ofs(paddr, `ISSR_OFS_STAT);

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	issr_pkg::issr_byte_t sre_q, ese_q, eseb_q;
	logic remote_q, cls;
	assign cls = wr_en && is_ofs(paddr, `ISSR_OFS_CTRL) &&
		pwdata[`ISSR_CTRL_CLS];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sre_q <= `ISSR_RST_BYTE;
			ese_q <= `ISSR_RST_BYTE;
			eseb_q <= `ISSR_RST_BYTE;
			remote_q <= 1'b0;
		end
		else if (wr_en)
		begin
			if (is_ofs(paddr, `ISSR_OFS_SRE))
				sre_q <= pwdata[7:0]; // R2
			if (is_ofs(paddr, `ISSR_OFS_ESE))
				ese_q <= pwdata[7:0]; // R8
			if (is_ofs(paddr, `ISSR_OFS_ESEB))
				eseb_q <= pwdata[7:0]; // R7
			if (is_ofs(paddr, `ISSR_OFS_CTRL))
				remote_q <= pwdata[`ISSR_CTRL_REMOTE];
		end
	end

	// ------------------------------------------------------------
	// Event status registers
	// ------------------------------------------------------------
	issr_evt_if eva();
	issr_evt_if evb();

	always_comb
	begin
		eva.set_bits = 8'h00;
		eva.set_bits[`ISSR_ESR_CTL] = in_q[0]; // R6
		eva.set_bits[`ISSR_ESR_SYN] = in_q[1]; // R8
		eva.set_bits[`ISSR_ESR_KEY] = key_s && remote_q; // R6
	end
	// Clear on the edge that captures read data, so no bit is lost unseen
	assign eva.rd_clr = rd_setup && is_ofs(paddr, `ISSR_OFS_ESR); // R9
	assign eva.cls = cls;
	assign eva.mask = ese_q;
	assign evb.set_bits = in_q[11:4];
	assign evb.rd_clr = rd_setup && is_ofs(paddr, `ISSR_OFS_ESRB); // R9
	assign evb.cls = cls;
	assign evb.mask = eseb_q;

	issr_evt_reg u_eva
	(
		.pclk(pclk),
		.presetn(presetn),
		.ev(eva)
	);

	issr_evt_reg u_evb
	(
		.pclk(pclk),
		.presetn(presetn),
		.ev(evb)
	);

	// ------------------------------------------------------------
	// Error queue count
	// ------------------------------------------------------------
	// Only the fill level is kept; entry storage lives elsewhere
	logic [4:0] errq_cnt_q;
	logic errq_pop;
	assign errq_pop = rd_en && is_ofs(paddr, `ISSR_OFS_ERRQ) &&
		(errq_cnt_q != 5'h00);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			errq_cnt_q <= 5'h00;
		else if (preset_s)
			errq_cnt_q <= 5'h00; // R13
		else if (err_pulse && !errq_pop &&
			errq_cnt_q < 5'(ERRQ_DEPTH))
			errq_cnt_q <= errq_cnt_q + 5'h01; // R13
		else if (errq_pop && !err_pulse)
			errq_cnt_q <= errq_cnt_q - 5'h01; // R13
	end

	// ------------------------------------------------------------
	// Error service request
	// ------------------------------------------------------------
	// Raised only when an entry arrives with bit 3 enabled, so a mask
	// rewrite drops it even while entries remain in the queue
	logic sre_wr, err_add, err_en, err_srq_q;
	assign sre_wr = wr_en && is_ofs(paddr, `ISSR_OFS_SRE);
	assign err_add = err_pulse && (errq_cnt_q < 5'(ERRQ_DEPTH));
	assign err_en = sre_wr ? pwdata[`ISSR_STB_ERR] : sre_q[`ISSR_STB_ERR];

	// A new entry wins over a mask write or an empty queue
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_srq_q <= 1'b0;
		else if (err_add && err_en && !preset_s)
			err_srq_q <= 1'b1; // R3
		else if (sre_wr || preset_s || errq_cnt_q == 5'h00)
			err_srq_q <= 1'b0; // R4
	end

	// ------------------------------------------------------------
	// Status byte and service request
	// ------------------------------------------------------------
	issr_pkg::issr_byte_t stb, lvl_mask;
	logic srq;
	always_comb
	begin
		lvl_mask = sre_q;
		lvl_mask[`ISSR_STB_ERR] = 1'b0; // R4
		stb = 8'h00;
		stb[`ISSR_STB_ERR] = errq_cnt_q != 5'h00; // R1
		stb[`ISSR_STB_ESA] = eva.summary; // R5
		stb[`ISSR_STB_ESB] = evb.summary; // R7
	end
	// Bits 2 and 5 request service as levels, bit 3 through its latch
	assign srq = |(stb & lvl_mask) | err_srq_q; // R3 R14

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			srq_n_o <= 1'b1;
			srq_n_oe <= 1'b0;
			svc_led <= 1'b0;
		end
		else
		begin
			srq_n_o <= 1'b0; // R3
			srq_n_oe <= srq; // R3 R14
			svc_led <= srq; // R3
		end
	end

	// ------------------------------------------------------------
	// Key code reply
	// ------------------------------------------------------------
	issr_pkg::issr_code_t key_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_q <= 16'sh0000;
			key_local <= 1'b0;
		end
		else
		begin
			if (key_pulse && remote_q)
				key_q <= kc3_q; // R10 R11
			key_local <= key_pulse && !remote_q; // R11
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				`ISSR_OFS_STB: prdata <= {24'h0, stb};
				`ISSR_OFS_SRE: prdata <= {24'h0, sre_q};
				`ISSR_OFS_ESR: prdata <= {24'h0, eva.latched};
				`ISSR_OFS_ESE: prdata <= {24'h0, ese_q};
				`ISSR_OFS_ESRB: prdata <= {24'h0, evb.latched};
				`ISSR_OFS_ESEB: prdata <= {24'h0, eseb_q};
				`ISSR_OFS_ERRQ: prdata <= {27'h0, errq_cnt_q};
				`ISSR_OFS_KEY: prdata <= {{16{key_q[15]}}, key_q}; // R10
				`ISSR_OFS_CTRL: prdata <= {31'h0, remote_q};
				`ISSR_OFS_STAT: prdata <= {31'h0, srq};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Zero wait state slave; unmapped addresses answer with an error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
		end
	end
endmodule

/* File: verilog/issr_defs.svh */
`ifndef ISSR_DEFS_SVH
`define ISSR_DEFS_SVH

// Register byte offsets
`define ISSR_OFS_STB 12'h000
`define ISSR_OFS_SRE 12'h004
`define ISSR_OFS_ESR 12'h008
`define ISSR_OFS_ESE 12'h00C
`define ISSR_OFS_ESRB 12'h010
`define ISSR_OFS_ESEB 12'h014
`define ISSR_OFS_ERRQ 12'h018
`define ISSR_OFS_KEY 12'h01C
`define ISSR_OFS_CTRL 12'h020
`define ISSR_OFS_STAT 12'h024

// Status byte bit positions
`define ISSR_STB_ESB 2
`define ISSR_STB_ERR 3
`define ISSR_STB_ESA 5

// Event status bit positions
`define ISSR_ESR_CTL 1
`define ISSR_ESR_SYN 5
`define ISSR_ESR_KEY 6

// Control register fields
`define ISSR_CTRL_REMOTE 0
`define ISSR_CTRL_CLS 1

// Knob code decoding
`define ISSR_KNOB_LIMIT (-400)
`define ISSR_KNOB_BIAS 32768

// Reset values and error queue depth
`define ISSR_RST_BYTE 8'h00
`define ISSR_ERRQ_DEPTH 20

`endif

/* File: verilog/issr_pkg.sv */
package issr_pkg;
	typedef logic [7:0] issr_byte_t;
	typedef logic signed [15:0] issr_code_t;
	typedef enum logic [1:0]
	{
		ISSR_IDLE = 2'b00,
		ISSR_ACCESS = 2'b01
	} issr_apb_st_t;
endpackage

/* File: verilog/issr_evt_if.sv */
interface issr_evt_if;
	logic [7:0] set_bits;
	logic rd_clr;
	logic cls;
	logic [7:0] mask;
	logic [7:0] latched;
	logic summary;
	modport owner
	(
		input set_bits,
		input rd_clr,
		input cls,
		input mask,
		output latched,
		output summary
	);
	modport user
	(
		output set_bits,
		output rd_clr,
		output cls,
		output mask,
		input latched,
		input summary
	);
endinterface

/* File: verilog/issr_evt_reg.sv */
`include "issr_defs.svh"

module issr_evt_reg
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Event register access
	issr_evt_if.owner ev
);
	logic [7:0] prev_q;
	logic [7:0] lat_q;
	logic [7:0] onset;

	assign onset = ev.set_bits & ~prev_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_q <= `ISSR_RST_BYTE;
		else
			prev_q <= ev.set_bits;
	end

	// Onset wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lat_q <= `ISSR_RST_BYTE;
		else if (ev.rd_clr || ev.cls)
			lat_q <= onset; // R12 R9
		else
			lat_q <= lat_q | onset; // R12
	end

	assign ev.latched = lat_q;
	assign ev.summary = |(lat_q & ev.mask);
endmodule

/* File: tb/issr_top_asserts.sv */
module issr_top_asserts
#(
	parameter int ERRQ_DEPTH = 20
)
(
	// APB side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Request line and panel
	input wire logic srq_n_o,
	input wire logic srq_n_oe,
	input wire logic svc_led,
	input wire logic key_local
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Remote mode as last written
	// ----
	logic remote_q;
	logic acc;
	assign acc = psel && penable && pready;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			remote_q <= 1'b0;
		else if (acc && pwrite && paddr == 12'h020)
			remote_q <= pwdata[0];
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_READY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_RDY_QUAL: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_UNMAP: assert property (psel && !penable && paddr > 12'h024 |=> pslverr)
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (pready && paddr <= 12'h024 &&
		paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	AST_LED: assert property (svc_led == srq_n_oe)
		else $error("indicator differs from request");
	AST_SRQ_PIN: assert property ($past(presetn) |-> !srq_n_o)
		else $error("request pin drives high");
	AST_KEY_PULSE: assert property (key_local |=> !key_local)
		else $error("local key pulse too long");
	AST_KEY_REMOTE: assert property (key_local |-> !$past(remote_q))
		else $error("key function in remote mode");
	AST_SRQ_OFF: assert property (acc && pwrite && paddr == 12'h004 &&
		pwdata[7:0] == 8'h00 |-> ##[1:2] !srq_n_oe)
		else $error("request stays with mask cleared");
endmodule

bind issr_top issr_top_asserts #(.ERRQ_DEPTH(ERRQ_DEPTH)) u_issr_top_asserts
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .srq_n_o(srq_n_o), .srq_n_oe(srq_n_oe),
	.svc_led(svc_led), .key_local(key_local)
);

/* File: tb/issr_ctl_model.sv */
module issr_ctl_model
(
	// Device side
	input wire logic srq_n_o,
	input wire logic srq_n_oe,
	// Controller view
	output logic srq_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// Line has a pull-up, so it reads high unless pulled
	assign srq_line = srq_n_oe ? srq_n_o : 1'b1;
endmodule

/* File: tb/issr_top_tb.sv */
module issr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	// Preset, error, control request, syntax error, key
	logic [4:0] ev = 5'h00;
	logic [15:0] key_code = 16'h0000;
	logic [7:0] evb_set = 8'h00;
	logic [31:0] prdata, rd;
	logic pready, pslverr, se, srq_n_o, srq_n_oe, svc_led, key_local, srq_line;
	logic [15:0] code;
	logic [7:0] b;
	int err_total = 0;
	int checks = 0;
	int nkey = 0;
	int nerr, errs, esr, ese, esrb, eseb, sre;
	logic esrq = 1'b0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (key_local === 1'b1) nkey++;
	issr_top #(.ERRQ_DEPTH(20)) u_issr_top
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .err_push(ev[3]),
		.ctl_req(ev[2]), .syntax_err(ev[1]), .key_press(ev[0]),
		.key_code(key_code), .evb_set(evb_set), .preset_cmd(ev[4]),
		.srq_n_o(srq_n_o), .srq_n_oe(srq_n_oe), .svc_led(svc_led),
		.key_local(key_local)
	);
	issr_ctl_model u_issr_ctl_model
	(
		.srq_n_o(srq_n_o), .srq_n_oe(srq_n_oe), .srq_line(srq_line)
	);
	// ----
	// Bus, pins and reference model
	// ----
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic pins(input logic [4:0] v);
		ev <= v;
		repeat (6) @(posedge pclk);
		ev <= 5'h00;
		repeat (8) @(posedge pclk);
	endtask
	function automatic int stb();
		return (errs > 0 ? 8 : 0) | ((esr & ese) != 0 ? 32 : 0)
			| ((esrb & eseb) != 0 ? 4 : 0);
	endfunction
	// Status byte and request line against the model
	task automatic look();
		logic req;
		apb(1'b0, 12'h000, 0);
		req = ((stb() & sre & 32'hF7) != 0) || esrq;
		chk(32'(stb()), rd);
		chk(32'h0, {31'b0, se});
		chk({31'b0, !req}, {31'b0, srq_line});
		chk({31'b0, req}, {31'b0, svc_led});
	endtask
	task automatic summarize();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		err_total++;
		summarize();
	end
	initial
	begin
		{errs, esr, ese, esrb, eseb, sre} = '0;
		void'($urandom(32'h3F87));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		look();
		apb(1'b0, 12'h040, 0);
		chk(32'h1, {31'b0, se});
		chk(32'h0, rd);
		nerr = $urandom_range(4, 2);
		sre = 8;
		apb(1'b1, 12'h004, sre);
		repeat (nerr) pins(5'h08);
		errs = nerr;
		esrq = 1'b1;
		look();
		sre = 0;
		apb(1'b1, 12'h004, sre);
		esrq = 1'b0;
		look();
		sre = 8;
		apb(1'b1, 12'h004, sre);
		look();
		pins(5'h08);
		errs++;
		esrq = 1'b1;
		look();
		for (int i = errs; i > 0; i--)
		begin
			apb(1'b0, 12'h018, 0);
			chk(32'(i), rd);
		end
		errs = 0;
		esrq = 1'b0;
		look();
		pins(5'h08);
		pins(5'h10);
		look();
		ese = 32;
		apb(1'b1, 12'h00C, ese);
		sre = 32;
		apb(1'b1, 12'h004, sre);
		pins(5'h04);
		esr = 2;
		look();
		pins(5'h02);
		esr = 34;
		look();
		apb(1'b0, 12'h008, 0);
		chk(32'(esr), rd);
		esr = 0;
		look();
		apb(1'b1, 12'h020, 1);
		code = 16'h8000 | 16'($urandom);
		key_code <= code;
		pins(5'h01);
		esr = 64;
		ese = 66;
		apb(1'b1, 12'h00C, ese);
		look();
		apb(1'b0, 12'h01C, 0);
		chk({{16{code[15]}}, code}, rd);
		chk(32'h0, 32'(nkey));
		apb(1'b1, 12'h020, 0);
		pins(5'h01);
		chk(32'h1, 32'(nkey));
		look();
		b = 8'($urandom_range(255, 1));
		evb_set <= b;
		repeat (8) @(posedge pclk);
		eseb = 255;
		apb(1'b1, 12'h014, eseb);
		esrb = b;
		look();
		apb(1'b0, 12'h010, 0);
		chk(32'(b), rd);
		esrb = 0;
		look();
		pins(5'h04);
		esr = esr | 2;
		apb(1'b1, 12'h020, 2);
		esr = 0;
		look();
		summarize();
	end
endmodule
